// ### rtl/rtcw_top.sv
// rtc register bank: calendar, calibration, watchdog, alarm, flags and interrupt pin
`timescale 1ns/1ps
`include "rtcw_map.svh"

// Functional notes
// - month is bcd, one-bit tens and four-bit units, counting 1 to 12
// - date is bcd 1 to 31, rolling per month length with leap february
// - oscillator stop bit: 1 halts the time base, 0 lets it run
// - calibration sign picks adding or subtracting the correction
// - watchdog period is six bits of 32 hz ticks, 31.25 ms up to 3Fh
// - watchdog period zero disables timeouts entirely
// - period bits take writes only while the guard bit is 0
// - polarity 1 drives interrupt active high, 0 gives open-drain active low
// - alarm field top bit 0 compares the field, 1 ignores it
// - write-time bit 1 freezes visible clock registers, counters keep running
// - clock, alarm, calibration, interrupt writes and flags bits other than write-time and read-time need write-time bit 1
// - clearing write-time blocks writes and loads changed time into counters
// - write-time and read-time bits are 0 after reset
// - read-time bit 1 captures the time into stable holding registers
// - read-time bit 0 lets holding registers follow the live clock while write-time is also 0
// - strobe reloads the watchdog; timeout at zero sets the watchdog flag
// - pulse mode drives interrupt about 200 ms, level mode until flags read
// - per-source interrupt enables gate the pin; flags set regardless
// - match of all unmasked alarm fields sets alarm flag and interrupt
module rtcw_top #(
	parameter int unsigned TICK_CYC = `RTCW_TICK_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [14:0] addr,
	input wire logic [7:0] dq_i,
	input wire logic powerfail,
	output logic [7:0] dq_o,
	output logic dq_oe_n,
	output logic int_o,
	output logic int_oe_n
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [26:0] s1_ff;
	logic [26:0] s2_ff;
	logic ce_s, we_s, oe_s, pf_s;
	logic [14:0] addr_s;
	logic [7:0] data_s;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			// power monitor resets low like its edge register, so reset gives no false edge
			s1_ff <= {3'h7, 1'b0, 23'h000000};
			s2_ff <= {3'h7, 1'b0, 23'h000000};
		end else begin
			s1_ff <= {ce_n, we_n, oe_n, powerfail, addr, dq_i};
			s2_ff <= s1_ff;
		end
	end
	assign {ce_s, we_s, oe_s, pf_s, addr_s, data_s} = s2_ff;

	// ----------------------------------------
	// time base
	// ----------------------------------------
	logic [31:0] pre_ff, nxt_pre;
	logic [4:0] sub_ff, nxt_sub;
	logic [31:0] per, adj;
	logic tick32, tick1;
	rtcw_pkg::rtcw_byte_t cal_ff;

	always_comb begin
		adj = 32'(cal_ff[4:0]) * 32'(`RTCW_CAL_STEP);
		// positive sign shortens the tick period, so the clock gains
		per = cal_ff[`RTCW_CAL_SIGN] ? TICK_CYC - adj : TICK_CYC + adj;
		tick32 = !cal_ff[`RTCW_CAL_STOP] && pre_ff == 32'h0;
		tick1 = tick32 && sub_ff == 5'h1F;
		nxt_pre = pre_ff;
		nxt_sub = sub_ff;
		if (!cal_ff[`RTCW_CAL_STOP]) begin
			nxt_pre = (pre_ff == 32'h0) ? per - 32'h1 : pre_ff - 32'h1;
			if (tick32) begin
				nxt_sub = sub_ff + 5'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pre_ff <= 32'h0;
			sub_ff <= 5'h00;
		end else begin
			pre_ff <= nxt_pre;
			sub_ff <= nxt_sub;
		end
	end

	// ----------------------------------------
	// calendar: 0 sec 1 min 2 hr 3 date 4 mon 5 year 6 cent 7 weekday
	// ----------------------------------------
	rtcw_pkg::rtcw_byte_t live_ff [0:7];
	rtcw_pkg::rtcw_byte_t nxt_live [0:7];
	rtcw_pkg::rtcw_byte_t sh_ff [0:7];
	rtcw_pkg::rtcw_byte_t nxt_sh [0:7];
	rtcw_pkg::rtcw_byte_t inc [0:7];
	rtcw_pkg::rtcw_byte_t lo [0:7];
	rtcw_pkg::rtcw_byte_t hi [0:7];
	logic [7:0] wrap, en;
	logic [7:0] carry;
	logic dirty_ff, nxt_dirty;
	logic w_ff, r_ff;
	logic load;
	logic tm_we;
	logic [2:0] tm_idx;
	rtcw_pkg::rtcw_byte_t tm_dat;
	logic [7:0] days;
	logic leap;

	always_comb begin
		if (live_ff[5] == 8'h00) begin
			leap = (live_ff[6][4] == 1'b0) ? (live_ff[6][3:0] % 4'h4 == 4'h0)
				: (live_ff[6][3:0] == 4'h2 || live_ff[6][3:0] == 4'h6);
		end else begin
			leap = (live_ff[5][4] == 1'b0) ? (live_ff[5][3:0] % 4'h4 == 4'h0)
				: (live_ff[5][3:0] == 4'h2 || live_ff[5][3:0] == 4'h6);
		end
		case (live_ff[4])
			8'h02: days = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: days = 8'h30;
			default: days = 8'h31;
		endcase
		hi[0] = 8'h59;
		hi[1] = 8'h59;
		hi[2] = 8'h23;
		hi[3] = days;
		hi[4] = 8'h12;
		hi[5] = 8'h99;
		hi[6] = 8'h99;
		hi[7] = 8'h07;
		lo[0] = 8'h00;
		lo[1] = 8'h00;
		lo[2] = 8'h00;
		lo[3] = 8'h01;
		lo[4] = 8'h01;
		lo[5] = 8'h00;
		lo[6] = 8'h00;
		lo[7] = 8'h01;
		carry[0] = tick1;
		for (int k = 1; k < 8; k++) begin
			carry[k] = carry[k - 1] & wrap[k - 1];
		end
		en = {carry[3], carry[6:0]};
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_fld
			rtcw_bcd2 u_inc (
				.cur(live_ff[gi]),
				.lo(lo[gi]),
				.hi(hi[gi]),
				.nxt(inc[gi]),
				.wrap(wrap[gi])
			);
		end
	endgenerate

	always_comb begin
		nxt_dirty = dirty_ff;
		if (load || !w_ff) begin
			nxt_dirty = 1'b0;
		end
		if (tm_we) begin
			nxt_dirty = 1'b1;
		end
		for (int k = 0; k < 8; k++) begin
			nxt_live[k] = load ? sh_ff[k] : (en[k] ? inc[k] : live_ff[k]);
			nxt_sh[k] = sh_ff[k];
			if (tm_we && tm_idx == 3'(k)) begin
				nxt_sh[k] = tm_dat;
			end else if (!w_ff && !r_ff) begin
				nxt_sh[k] = live_ff[k];
			end
			// holding while either bit is set gives and
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int k = 0; k < 8; k++) begin
				live_ff[k] <= (k == 3 || k == 4 || k == 7) ? `RTCW_RST_ONE : `RTCW_RST_TIME;
				sh_ff[k] <= (k == 3 || k == 4 || k == 7) ? `RTCW_RST_ONE : `RTCW_RST_TIME;
			end
			dirty_ff <= 1'b0;
		end else begin
			live_ff <= nxt_live;
			sh_ff <= nxt_sh;
			dirty_ff <= nxt_dirty;
		end
	end

	// ----------------------------------------
	// bus, registers and flags
	// ----------------------------------------
	rtcw_pkg::rtcw_bus_t st_ff, nxt_st;
	logic [14:0] wa_ff, nxt_wa;
	rtcw_pkg::rtcw_byte_t wd_ff, nxt_wd;
	rtcw_pkg::rtcw_byte_t al_ff [0:3];
	rtcw_pkg::rtcw_byte_t nxt_al [0:3];
	rtcw_pkg::rtcw_byte_t icfg_ff, nxt_icfg, nxt_cal, dq_ff, nxt_dq;
	logic [5:0] wdp_ff, nxt_wdp;
	logic guard_ff, nxt_guard, oe_ff, nxt_oe;
	logic wdf_ff, af_ff, pf_ff, oscillator_fail_flag_ff, calb_ff;
	logic nxt_wdf, nxt_af, nxt_pf, nxt_oscillator_fail_flag, nxt_calb, nxt_w, nxt_r;
	logic commit, fl_read, strobe, wd_to, al_hit, pf_d_ff, tick1_d_ff, pf_rise;
	rtcw_pkg::rtcw_byte_t rd;

	rtcw_wdog u_wdog (
		.mclk(mclk),
		.rstn(rstn),
		.tick(tick32),
		.period(wdp_ff),
		.reload(strobe),
		.timeout(wd_to)
	);

	always_comb begin
		al_hit = tick1_d_ff;
		al_hit &= al_ff[0][`RTCW_AL_MASK] || al_ff[0][6:0] == live_ff[0][6:0];
		al_hit &= al_ff[1][`RTCW_AL_MASK] || al_ff[1][6:0] == live_ff[1][6:0];
		al_hit &= al_ff[2][`RTCW_AL_MASK] || al_ff[2][6:0] == live_ff[2][6:0];
		al_hit &= al_ff[3][`RTCW_AL_MASK] || al_ff[3][6:0] == live_ff[3][6:0];
		pf_rise = pf_s && !pf_d_ff;
		case (addr_s)
			`RTCW_A_FLAGS: rd = {wdf_ff, af_ff, pf_ff, oscillator_fail_flag_ff, 1'b0, calb_ff, w_ff, r_ff};
			`RTCW_A_CENT: rd = sh_ff[6];
			`RTCW_A_ASEC: rd = al_ff[0];
			`RTCW_A_AMIN: rd = al_ff[1];
			`RTCW_A_AHR: rd = al_ff[2];
			`RTCW_A_ADATE: rd = al_ff[3];
			`RTCW_A_INTCFG: rd = icfg_ff;
			`RTCW_A_WDOG: rd = {1'b0, guard_ff, wdp_ff};
			`RTCW_A_CAL: rd = cal_ff;
			`RTCW_A_SEC: rd = sh_ff[0];
			`RTCW_A_MIN: rd = sh_ff[1];
			`RTCW_A_HR: rd = sh_ff[2];
			`RTCW_A_WDAY: rd = sh_ff[7];
			`RTCW_A_DATE: rd = sh_ff[3];
			`RTCW_A_MON: rd = sh_ff[4];
			`RTCW_A_YEAR: rd = sh_ff[5];
			default: rd = 8'h00;
		endcase
		nxt_st = st_ff;
		nxt_wa = wa_ff;
		nxt_wd = wd_ff;
		nxt_dq = dq_ff;
		fl_read = 1'b0;
		commit = 1'b0;
		case (st_ff)
			rtcw_pkg::RTCW_BUS_IDLE: begin
				if (!ce_s && !we_s) begin
					nxt_st = rtcw_pkg::RTCW_BUS_WRITE;
				end else if (!ce_s) begin
					nxt_st = rtcw_pkg::RTCW_BUS_READ;
					nxt_dq = rd;
					fl_read = (addr_s == `RTCW_A_FLAGS);
				end
			end
			rtcw_pkg::RTCW_BUS_READ: begin
				if (ce_s) begin
					nxt_st = rtcw_pkg::RTCW_BUS_IDLE;
				end else if (!we_s) begin
					nxt_st = rtcw_pkg::RTCW_BUS_WRITE;
				end
			end
			rtcw_pkg::RTCW_BUS_WRITE: begin
				if (ce_s || we_s) begin
					commit = 1'b1;
					nxt_st = ce_s ? rtcw_pkg::RTCW_BUS_IDLE : rtcw_pkg::RTCW_BUS_READ;
				end
			end
			default: nxt_st = rtcw_pkg::RTCW_BUS_IDLE;
		endcase
		if (!ce_s && !we_s) begin
			nxt_wa = addr_s;
			nxt_wd = data_s;
		end
		nxt_oe = !(nxt_st == rtcw_pkg::RTCW_BUS_READ && !oe_s);
		nxt_al = al_ff;
		nxt_icfg = icfg_ff;
		nxt_cal = cal_ff;
		nxt_wdp = wdp_ff;
		nxt_guard = guard_ff;
		nxt_oscillator_fail_flag = oscillator_fail_flag_ff;
		nxt_calb = calb_ff;
		nxt_w = w_ff;
		nxt_r = r_ff;
		strobe = 1'b0;
		tm_we = 1'b0;
		tm_idx = 3'h0;
		tm_dat = wd_ff;
		if (commit) begin
			case (wa_ff)
				`RTCW_A_FLAGS: begin
					nxt_w = wd_ff[`RTCW_FL_W];
					nxt_r = wd_ff[`RTCW_FL_R];
					if (w_ff) begin
						nxt_calb = wd_ff[`RTCW_FL_CAL];
						nxt_oscillator_fail_flag = oscillator_fail_flag_ff & wd_ff[`RTCW_FL_OSCILLATOR_FAIL_FLAG];
					end
				end
				`RTCW_A_WDOG: begin
					strobe = wd_ff[`RTCW_WD_STROBE];
					nxt_guard = wd_ff[`RTCW_WD_GUARD];
					// the guard as it stood before this cycle decides
					if (!guard_ff) begin
						nxt_wdp = wd_ff[5:0];
					end
				end
				`RTCW_A_ASEC: nxt_al[0] = w_ff ? wd_ff : al_ff[0];
				`RTCW_A_AMIN: nxt_al[1] = w_ff ? wd_ff : al_ff[1];
				`RTCW_A_AHR: nxt_al[2] = w_ff ? wd_ff : al_ff[2];
				`RTCW_A_ADATE: nxt_al[3] = w_ff ? wd_ff : al_ff[3];
				`RTCW_A_INTCFG: nxt_icfg = w_ff ? {wd_ff[7:2], 2'b00} : icfg_ff;
				`RTCW_A_CAL: nxt_cal = w_ff ? {wd_ff[7], 1'b0, wd_ff[5:0]} : cal_ff;
				`RTCW_A_SEC: tm_idx = 3'h0;
				`RTCW_A_MIN: tm_idx = 3'h1;
				`RTCW_A_HR: tm_idx = 3'h2;
				`RTCW_A_DATE: tm_idx = 3'h3;
				`RTCW_A_MON: tm_idx = 3'h4;
				`RTCW_A_YEAR: tm_idx = 3'h5;
				`RTCW_A_CENT: tm_idx = 3'h6;
				`RTCW_A_WDAY: tm_idx = 3'h7;
				default: tm_idx = 3'h0;
			endcase
			tm_we = w_ff && (wa_ff == `RTCW_A_CENT || wa_ff >= `RTCW_A_SEC);
		end
		load = w_ff && !nxt_w && dirty_ff;
		// set wins over the read clear; flags set regardless of enables
		nxt_wdf = wd_to | (wdf_ff & !fl_read);
		nxt_af = al_hit | (af_ff & !fl_read);
		nxt_pf = pf_rise | (pf_ff & !fl_read);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= rtcw_pkg::RTCW_BUS_IDLE;
			wa_ff <= 15'h0000;
			wd_ff <= 8'h00;
			dq_ff <= 8'h00;
			oe_ff <= 1'b1;
			for (int k = 0; k < 4; k++) begin
				al_ff[k] <= `RTCW_RST_ALARM;
			end
			icfg_ff <= `RTCW_RST_INTCFG;
			cal_ff <= `RTCW_RST_CAL;
			wdp_ff <= 6'h00;
			guard_ff <= 1'b0;
			{wdf_ff, af_ff, pf_ff, oscillator_fail_flag_ff, calb_ff} <= 5'h00;
			w_ff <= 1'b0;
			r_ff <= 1'b0;
			pf_d_ff <= 1'b0;
			tick1_d_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			wa_ff <= nxt_wa;
			wd_ff <= nxt_wd;
			dq_ff <= nxt_dq;
			oe_ff <= nxt_oe;
			al_ff <= nxt_al;
			icfg_ff <= nxt_icfg;
			cal_ff <= nxt_cal;
			wdp_ff <= nxt_wdp;
			guard_ff <= nxt_guard;
			{wdf_ff, af_ff, pf_ff, oscillator_fail_flag_ff, calb_ff} <= {nxt_wdf, nxt_af, nxt_pf, nxt_oscillator_fail_flag, nxt_calb};
			w_ff <= nxt_w;
			r_ff <= nxt_r;
			pf_d_ff <= pf_s;
			tick1_d_ff <= tick1;
		end
	end

	// ----------------------------------------
	// interrupt pin
	// ----------------------------------------
	logic act_ff, nxt_act, io_ff, nxt_io, ioe_ff, nxt_ioe;
	logic [2:0] pc_ff, nxt_pc;
	logic ev;

	always_comb begin
		ev = (wd_to & icfg_ff[`RTCW_IE_WD]) | (al_hit & icfg_ff[`RTCW_IE_AL])
			| (pf_rise & icfg_ff[`RTCW_IE_PF]);
		nxt_act = act_ff;
		nxt_pc = pc_ff;
		if (ev) begin
			nxt_act = 1'b1;
			nxt_pc = 3'(`RTCW_PULSE_TICKS);
		end else if (fl_read) begin
			nxt_act = 1'b0;
		end else if (icfg_ff[`RTCW_IE_PL] && act_ff && tick32) begin
			nxt_pc = pc_ff - 3'h1;
			nxt_act = (pc_ff > 3'h1);
		end
		// pulse length follows the 32 hz tick, so a stopped oscillator stretches it
		nxt_io = icfg_ff[`RTCW_IE_HL] & nxt_act;
		nxt_ioe = icfg_ff[`RTCW_IE_HL] ? 1'b0 : !nxt_act;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			act_ff <= 1'b0;
			pc_ff <= 3'h0;
			io_ff <= 1'b0;
			ioe_ff <= 1'b1;
		end else begin
			act_ff <= nxt_act;
			pc_ff <= nxt_pc;
			io_ff <= nxt_io;
			ioe_ff <= nxt_ioe;
		end
	end

	assign dq_o = dq_ff;
	assign dq_oe_n = oe_ff;
	assign int_o = io_ff;
	assign int_oe_n = ioe_ff;
endmodule

// ### inc/rtcw_map.svh
// register addresses, field positions, reset values and timing counts of the rtc block
`ifndef RTCW_MAP_SVH
`define RTCW_MAP_SVH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define RTCW_A_FLAGS 15'h7FF0
`define RTCW_A_CENT 15'h7FF1
`define RTCW_A_ASEC 15'h7FF2
`define RTCW_A_AMIN 15'h7FF3
`define RTCW_A_AHR 15'h7FF4
`define RTCW_A_ADATE 15'h7FF5
`define RTCW_A_INTCFG 15'h7FF6
`define RTCW_A_WDOG 15'h7FF7
`define RTCW_A_CAL 15'h7FF8
`define RTCW_A_SEC 15'h7FF9
`define RTCW_A_MIN 15'h7FFA
`define RTCW_A_HR 15'h7FFB
`define RTCW_A_WDAY 15'h7FFC
`define RTCW_A_DATE 15'h7FFD
`define RTCW_A_MON 15'h7FFE
`define RTCW_A_YEAR 15'h7FFF
// ----------------------------------------
// field positions
// ----------------------------------------
`define RTCW_FL_WDF 7
`define RTCW_FL_AF 6
`define RTCW_FL_PF 5
`define RTCW_FL_OSCILLATOR_FAIL_FLAG 4
`define RTCW_FL_CAL 2
`define RTCW_FL_W 1
`define RTCW_FL_R 0
`define RTCW_WD_STROBE 7
`define RTCW_WD_GUARD 6
`define RTCW_IE_WD 7
`define RTCW_IE_AL 6
`define RTCW_IE_PF 5
`define RTCW_IE_HL 3
`define RTCW_IE_PL 2
`define RTCW_CAL_STOP 7
`define RTCW_CAL_SIGN 5
`define RTCW_AL_MASK 7
// ----------------------------------------
// reset values
// ----------------------------------------
`define RTCW_RST_INTCFG 8'h00
`define RTCW_RST_CAL 8'h00
`define RTCW_RST_WDOG 8'h00
`define RTCW_RST_ALARM 8'h00
`define RTCW_RST_TIME 8'h00
`define RTCW_RST_ONE 8'h01
// ----------------------------------------
// timing
// ----------------------------------------
`define RTCW_CLK_HZ 100000000
`define RTCW_TICK_HZ 32
`define RTCW_TICK_CYC (`RTCW_CLK_HZ / `RTCW_TICK_HZ)
`define RTCW_PULSE_MS 200
`define RTCW_PULSE_TICKS ((`RTCW_PULSE_MS * `RTCW_TICK_HZ) / 1000)
`define RTCW_CAL_STEP 64
`endif

// ### inc/rtcw_pkg.sv
// shared types of the rtc block
package rtcw_pkg;
	typedef logic [7:0] rtcw_byte_t;
	typedef enum logic [1:0] {RTCW_BUS_IDLE, RTCW_BUS_READ, RTCW_BUS_WRITE} rtcw_bus_t;
endpackage

// ### rtl/rtcw_bcd2.sv
// two-digit bcd incrementer with wrap limits
`timescale 1ns/1ps
module rtcw_bcd2 (
	input wire logic [7:0] cur,
	input wire logic [7:0] lo,
	input wire logic [7:0] hi,
	output logic [7:0] nxt,
	output logic wrap
);
	// out-of-range values left by software wrap too, so a bad field heals
	always_comb begin
		wrap = (cur >= hi);
		if (wrap) begin
			nxt = lo;
		end else if (cur[3:0] >= 4'h9) begin
			nxt = {cur[7:4] + 4'h1, 4'h0};
		end else begin
			nxt = {cur[7:4], cur[3:0] + 4'h1};
		end
	end
endmodule

// ### rtl/rtcw_wdog.sv
// watchdog down-counter on the 32 hz tick
`timescale 1ns/1ps
module rtcw_wdog (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic [5:0] period,
	input wire logic reload,
	output logic timeout
);
	logic [5:0] cnt_ff;
	logic [5:0] nxt_cnt;
	logic to_ff;
	logic nxt_to;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_to = 1'b0;
		if (reload) begin
			nxt_cnt = period;
		end else if (tick && period != 6'h00) begin
			if (cnt_ff <= 6'h01) begin
				nxt_to = 1'b1;
				nxt_cnt = period;
			end else begin
				nxt_cnt = cnt_ff - 6'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= 6'h00;
			to_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			to_ff <= nxt_to;
		end
	end

	assign timeout = to_ff;
endmodule

// ### test/rtcw_top_chk.sv
// checker: pin-level assertions for the rtc register bank
`timescale 1ns/1ps
`include "rtcw_map.svh"
module rtcw_top_chk (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [14:0] addr,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe_n,
	input wire logic int_o,
	input wire logic int_oe_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// ----------------------------------------
	// read data
	// ----------------------------------------
	month_range_a: assert property (
		!dq_oe_n && addr == `RTCW_A_MON |-> dq_o inside {[8'h01:8'h09], [8'h10:8'h12]})
		else $error("month byte out of range");
	date_range_a: assert property (
		!dq_oe_n && addr == `RTCW_A_DATE |-> dq_o inside {[8'h01:8'h09], [8'h10:8'h19],
		[8'h20:8'h29], [8'h30:8'h31]}) else $error("date byte out of range");
	secmin_bcd_a: assert property (
		!dq_oe_n && (addr == `RTCW_A_SEC || addr == `RTCW_A_MIN)
		|-> dq_o[7:4] <= 4'h5 && dq_o[3:0] <= 4'h9) else $error("seconds or minutes not bcd 0-59");
	hour_bcd_a: assert property (
		!dq_oe_n && addr == `RTCW_A_HR |-> dq_o <= 8'h23 && dq_o[3:0] <= 4'h9)
		else $error("hours not bcd 0-23");
	strobe_reads0_a: assert property (
		!dq_oe_n && addr == `RTCW_A_WDOG |-> !dq_o[7]) else $error("strobe bit read back as 1");
	// held read data must not move while the host samples it
	read_hold_a: assert property (
		!dq_oe_n && $past(!dq_oe_n) |-> $stable(dq_o)) else $error("read data moved mid read");
	// ----------------------------------------
	// interrupt pin
	// ----------------------------------------
	int_drive_a: assert property (
		int_o |-> !int_oe_n) else $error("interrupt high without driver enabled");
	flags_clear_a: assert property (
		$fell(dq_oe_n) && addr == `RTCW_A_FLAGS |-> ##[1:3] !int_o)
		else $error("flags read did not end interrupt");
	cover property (!int_oe_n && !int_o);
	cover property (int_o);
	cover property ($fell(dq_oe_n) && addr == `RTCW_A_FLAGS);
endmodule

// ### test/rtcw_host.sv
// host model: asynchronous byte-wide bus master for the rtc block
`timescale 1ns/1ps
module rtcw_host (
	input wire logic mclk,
	input wire logic [7:0] dq,
	input wire logic dq_oe_n,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [14:0] addr,
	output logic [7:0] dq_h
);
	initial begin
		ce_n = 1'b1;
		we_n = 1'b1;
		oe_n = 1'b1;
		addr = 15'h0000;
		dq_h = 8'h00;
	end
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// data held three cycles past the strobe, since the device commits after its syncs
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		@(posedge mclk);
		ce_n <= 1'b0;
		we_n <= 1'b0;
		addr <= a;
		dq_h <= d;
		repeat (4) @(posedge mclk);
		ce_n <= 1'b1;
		we_n <= 1'b1;
		repeat (3) @(posedge mclk);
		// released bus shows the inverse, never a stale byte
		dq_h <= ~d;
		repeat (3) @(posedge mclk);
	endtask
	task automatic rd(input logic [14:0] a, output logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		ce_n <= 1'b0;
		oe_n <= 1'b0;
		addr <= a;
		do begin
			@(posedge mclk);
			n++;
		end while (dq_oe_n !== 1'b0 && n < 12);
		d = dq;
		ce_n <= 1'b1;
		oe_n <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask
endmodule

// ### test/rtcw_top_tb_top.sv
// testbench: rtc register bank exercised through the host bus model
`timescale 1ns/1ps
`include "rtcw_map.svh"
module rtcw_top_tb_top;
	// short tick keeps a second at 640 cycles
	localparam int unsigned TCYC = 20;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic powerfail = 1'b0;
	logic ce_n;
	logic we_n;
	logic oe_n;
	logic [14:0] addr;
	logic [7:0] dq_h;
	logic [7:0] dq_i;
	logic [7:0] dq_o;
	logic dq_oe_n;
	logic int_o;
	logic int_oe_n;
	logic [7:0] s1;
	logic [7:0] s2;
	int failures = 0;
	int check_count = 0;
	always #5 mclk = ~mclk;
	assign dq_i = dq_oe_n ? dq_h : dq_o;
	rtcw_host u_host (.mclk(mclk), .dq(dq_i), .dq_oe_n(dq_oe_n), .ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .addr(addr), .dq_h(dq_h));
	rtcw_top #(.TICK_CYC(TCYC)) u_dut (.mclk(mclk), .rstn(rstn), .ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .addr(addr), .dq_i(dq_i), .powerfail(powerfail), .dq_o(dq_o),
		.dq_oe_n(dq_oe_n), .int_o(int_o), .int_oe_n(int_oe_n));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_host.rd(a, d);
		chk(d, exp);
	endtask
	task automatic pins(input logic [7:0] exp);
		chk({6'h00, int_o, int_oe_n}, exp);
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		u_host.wr(a, d);
	endtask
	task automatic rd2(input logic [14:0] a, input int gap);
		u_host.rd(a, s1);
		cyc(gap);
		u_host.rd(a, s2);
	endtask
	task automatic report_and_stop();
		if (failures == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		cyc(5);
		rstn <= 1'b1;
		cyc(3);
		rdc(`RTCW_A_FLAGS, 8'h00);
		rdc(`RTCW_A_MON, 8'h01);
		rdc(`RTCW_A_DATE, 8'h01);
		rdc(15'h1234, 8'h00);
		wr(`RTCW_A_ASEC, 8'h05);
		rdc(`RTCW_A_ASEC, 8'h00);
		wr(`RTCW_A_FLAGS, 8'h02);
		wr(`RTCW_A_SEC, 8'h58);
		wr(`RTCW_A_MIN, 8'h59);
		wr(`RTCW_A_HR, 8'h23);
		wr(`RTCW_A_DATE, 8'h28);
		wr(`RTCW_A_MON, 8'h02);
		wr(`RTCW_A_YEAR, 8'h24);
		wr(`RTCW_A_FLAGS, 8'h00);
		cyc(1380);
		wr(`RTCW_A_FLAGS, 8'h01);
		rdc(`RTCW_A_YEAR, 8'h24);
		rdc(`RTCW_A_HR, 8'h00);
		rdc(`RTCW_A_MIN, 8'h00);
		rdc(`RTCW_A_DATE, 8'h29);
		rdc(`RTCW_A_MON, 8'h02);
		rd2(`RTCW_A_SEC, 700);
		chk({7'h00, s1 === s2}, 8'h01);
		wr(`RTCW_A_FLAGS, 8'h00);
		rd2(`RTCW_A_SEC, 700);
		chk({7'h00, s1 !== s2}, 8'h01);
		wr(`RTCW_A_FLAGS, 8'h02);
		wr(`RTCW_A_CAL, 8'hA5);
		wr(`RTCW_A_FLAGS, 8'h00);
		rdc(`RTCW_A_CAL, 8'hA5);
		rd2(`RTCW_A_SEC, 1400);
		chk({7'h00, s1 === s2}, 8'h01);
		wr(`RTCW_A_FLAGS, 8'h02);
		wr(`RTCW_A_CAL, 8'h00);
		wr(`RTCW_A_INTCFG, 8'h88);
		wr(`RTCW_A_FLAGS, 8'h00);
		wr(`RTCW_A_WDOG, 8'h3F);
		wr(`RTCW_A_WDOG, 8'hFF);
		wr(`RTCW_A_WDOG, 8'h45);
		rdc(`RTCW_A_WDOG, 8'h7F);
		cyc(1050);
		pins(8'h00);
		cyc(250);
		pins(8'h02);
		rdc(`RTCW_A_FLAGS, 8'h80);
		pins(8'h00);
		// guard cleared by an earlier write before the new period
		wr(`RTCW_A_WDOG, 8'h00);
		wr(`RTCW_A_WDOG, 8'h00);
		rdc(`RTCW_A_WDOG, 8'h00);
		cyc(1400);
		rdc(`RTCW_A_FLAGS, 8'h00);
		wr(`RTCW_A_FLAGS, 8'h02);
		wr(`RTCW_A_INTCFG, 8'h24);
		wr(`RTCW_A_FLAGS, 8'h00);
		pins(8'h01);
		powerfail <= 1'b1;
		cyc(10);
		pins(8'h00);
		cyc(60);
		pins(8'h00);
		cyc(100);
		pins(8'h01);
		rdc(`RTCW_A_FLAGS, 8'h20);
		powerfail <= 1'b0;
		wr(`RTCW_A_FLAGS, 8'h02);
		wr(`RTCW_A_INTCFG, 8'h00);
		wr(`RTCW_A_FLAGS, 8'h00);
		powerfail <= 1'b1;
		cyc(20);
		pins(8'h01);
		rdc(`RTCW_A_FLAGS, 8'h20);
		powerfail <= 1'b0;
		wr(`RTCW_A_FLAGS, 8'h02);
		rd2(`RTCW_A_SEC, 700);
		chk({7'h00, s1 === s2}, 8'h01);
		wr(`RTCW_A_ASEC, 8'h03);
		wr(`RTCW_A_AMIN, 8'h85);
		wr(`RTCW_A_AHR, 8'h85);
		wr(`RTCW_A_ADATE, 8'h85);
		wr(`RTCW_A_INTCFG, 8'h48);
		wr(`RTCW_A_SEC, 8'h00);
		wr(`RTCW_A_FLAGS, 8'h00);
		cyc(1200);
		pins(8'h00);
		cyc(800);
		pins(8'h02);
		rdc(`RTCW_A_FLAGS, 8'h40);
		report_and_stop();
	end
	// whole run needs about 10.4k cycles; nearly four times that is a hang
	initial begin
		#400000;
		failures++;
		report_and_stop();
	end
endmodule
bind rtcw_top rtcw_top_chk u_chk (.mclk(mclk), .rstn(rstn), .addr(addr), .dq_o(dq_o),
	.dq_oe_n(dq_oe_n), .int_o(int_o), .int_oe_n(int_oe_n));
